// File: rtl/ipb_builder.sv
// Interrupt parameter builder: fault detection and parameter word assembly
//
// Overview of operation
// [RQ1] Third word mode bit: 0 gives micro-step counter, 1 gives micromodule address.
// [RQ2] Parity faults carry card number in third word; residue faults leave it zero.
// [RQ3] Every microcode store access is parity checked; error raises store-parity interrupt.
// [RQ4] Every scratch RAM read is parity checked; error raises RAM-parity interrupt.
// [RQ5] Invalid residue on either adder input bus raises bus-residue interrupt.
// [RQ6] Residue not matching its operand raises adder-residue interrupt, residue saved.
// [RQ7] Residue sum compared with result residue; mismatch raises compare-residue interrupt.
// [RQ8] Hardware and general-control entries treat stack and counter like alarms.
// [RQ9] Second word is the top-of-stack word at detection.
// [RQ10] General-control first word: bit 22 class, causes at bits 3, 5, 4, 0.
// [RQ11] General-control bit 46 marks value-call evaluation, bit 44 vector operation.
// [RQ12] Bit 19 shows retry flip-flop; bit 18 flags scan error for global memory.
// [RQ13] Check-code-only error raises check-bit interrupt, logs it, program continues.
// [RQ14] Check-code error with data error escalates to alarm as multiple-bit error.
// [RQ15] Address error is retried; success continues, failure escalates to alarm.
// [RQ16] I/O-finished first word is constant with bits 20, 7, 4, 0 set.
// [RQ17] I/O-finished second and third words are all zero.
// [RQ18] I/O-finished raised when operation ends with control word bit 3 or 2 set.
// [RQ19] Consistent syllable-dependent interrupts back up all three program pointers.
// [RQ20] Syllable-dependent first word carries presence-bit operation flags.
// [RQ21] On entry first word goes to second stack register, first cleared, pointer backed up.
// [RQ22] Hardware first word sets bit 26.
// [RQ23] Syllable-dependent bits 24:23 are 01 inconsistent, 10 consistent.
// [RQ24] All three words are captured in the cycle the event is latched.
// [RQ25] Simultaneous hardware faults all set their cause flags.
`timescale 1ns/10ps
module ipb_builder
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // Machine state at the moment of detection
   input wire ipb_pkg::ipb_mstate_t mstate,
   // Microcode store and scratch RAM read ports
   input wire logic rom_access,
   input wire logic [31:0] rom_data,
   input wire logic rom_parity,
   input wire logic [7:0] rom_card,
   input wire logic ram_access,
   input wire logic [47:0] ram_data,
   input wire logic ram_parity,
   input wire logic [7:0] ram_card,
   // Address adder and residues
   input wire logic adder_active,
   input wire logic [19:0] adder_input_bus_a,
   input wire logic [19:0] adder_input_bus_b,
   input wire logic [1:0] residue_a,
   input wire logic [1:0] residue_b,
   input wire logic [20:0] adder_sum,
   // Memory controller reports
   input wire logic mem_read_done,
   input wire logic mem_check_bit_err,
   input wire logic mem_data_bit_err,
   input wire logic mem_single_corrected,
   input wire logic mem_data_retry,
   input wire logic mem_addr_err,
   input wire logic mem_retry_done,
   input wire logic mem_retry_ok,
   // Peripheral completion
   input wire logic io_op_done,
   input wire logic [47:0] io_control_word,
   // Syllable-dependent requests
   input wire logic sd_event,
   input wire logic sd_consistent,
   input wire logic [2:0] sd_presence,
   input wire logic [13:0] sd_cause,
   input wire logic [47:0] sd_p2,
   // Interrupt entry
   output logic int_valid,
   output ipb_pkg::ipb_class_t int_class,
   output ipb_pkg::ipb_params_t params,
   output logic [47:0] stack_second,
   output logic stack_first_clear,
   output logic iw_pointer_backup,
   output logic all_pointer_backup,
   output logic [3:0] residue_capture,
   // Memory recovery side effects
   output logic mem_retry_request,
   output logic error_log_request
);
   typedef enum logic [1:0]
   {
      IPB_RT_IDLE = 2'b00,
      IPB_RT_WAIT = 2'b01
   } ipb_retry_t;

   ipb_retry_t retry_state;
   ipb_retry_t next_retry_state;
   logic io_pending;

   wire logic rom_err;
   wire logic ram_err;
   wire logic bus_err;
   wire logic adder_err;
   wire logic compare_err;
   wire logic [3:0] bad_residue;
   wire logic [3:0] comparator;

   ipb_parity_check #(.DATA_W(32)) u_rom_par
   (
      .access(rom_access),
      .data(rom_data),
      .parity(rom_parity),
      .error(rom_err)
   );

   ipb_parity_check #(.DATA_W(48)) u_ram_par
   (
      .access(ram_access),
      .data(ram_data),
      .parity(ram_parity),
      .error(ram_err)
   );

   ipb_residue_check u_residue
   (
      .active(adder_active),
      .bus_a(adder_input_bus_a),
      .bus_b(adder_input_bus_b),
      .res_a(residue_a),
      .res_b(residue_b),
      .adder_sum(adder_sum),
      .bus_err(bus_err),
      .adder_err(adder_err),
      .compare_err(compare_err),
      .bad_residue(bad_residue),
      .comparator(comparator)
   );

   // Third word with machine fields; card only for parity faults
   function automatic logic [47:0] build_p3(input ipb_pkg::ipb_mstate_t s,
                                            input logic [7:0] card);
      logic [47:0] w;
      w = ipb_pkg::WORD_ZERO;
      w[ipb_pkg::P3_CARD_LO +: ipb_pkg::CARD_W] = card;
      w[ipb_pkg::P3_VE] = s.vector_mode_flag;
      w[ipb_pkg::P3_TE] = s.table_edit_flag;
      w[ipb_pkg::P3_E] = s.edit_flag;
      w[ipb_pkg::P3_V] = s.variant_flag;
      w[ipb_pkg::P3_OP_LO +: 4] = s.opcode;
      w[ipb_pkg::P3_STROBE_LO +: 4] = s.strobe;
      w[ipb_pkg::P3_MODE] = s.mode_select;
      w[ipb_pkg::LOW_W-1:0] = s.mode_select ? s.micromodule_addr : s.micro_step;
      return w;
   endfunction

   // Memory recovery events
   wire logic check_only;
   wire logic multi_bit;
   wire logic retry_start;
   wire logic retry_pass;
   wire logic retry_fail;

   assign check_only = mem_read_done & mem_check_bit_err & ~mem_data_bit_err; // RQ13
   assign multi_bit = mem_read_done & mem_check_bit_err & mem_data_bit_err; // RQ14
   assign retry_start = (retry_state == IPB_RT_IDLE) & mem_addr_err; // RQ15
   assign retry_pass = (retry_state == IPB_RT_WAIT) & mem_retry_done & mem_retry_ok;
   assign retry_fail = (retry_state == IPB_RT_WAIT) & mem_retry_done & ~mem_retry_ok;

   always_comb
   begin
      next_retry_state = retry_state;
      unique case (retry_state)
         IPB_RT_IDLE:
         begin
            if (retry_start)
               next_retry_state = IPB_RT_WAIT;
         end
         IPB_RT_WAIT:
         begin
            if (mem_retry_done)
               next_retry_state = IPB_RT_IDLE;
         end
         default: next_retry_state = IPB_RT_IDLE;
      endcase
   end

   // Class events
   wire logic hw_any;
   wire logic gc_any;
   wire logic alarm_any;
   wire logic io_event;
   wire logic io_take;

   assign hw_any = rom_err | ram_err | bus_err | adder_err | compare_err;
   assign gc_any = check_only | mem_single_corrected | mem_data_retry | retry_pass;
   assign alarm_any = multi_bit | retry_fail;
   assign io_event = io_op_done & (io_control_word[ipb_pkg::CW_FINISH_A]
                                   | io_control_word[ipb_pkg::CW_FINISH_B]); // RQ18
   assign io_take = (io_event | io_pending) & ~alarm_any & ~hw_any & ~gc_any & ~sd_event;

   // First words
   wire logic [47:0] hw_p1;
   wire logic [47:0] gc_p1;
   wire logic [47:0] al_p1;
   wire logic [47:0] sd_p1;
   wire logic [7:0] parity_card;

   // Both store and RAM faults together report the store card
   assign parity_card = rom_err ? rom_card : (ram_err ? ram_card : 8'h00); // RQ2
   assign hw_p1 = (48'h1 << ipb_pkg::BIT_HARDWARE) // RQ22
      | (48'(mstate.retry_ff) << ipb_pkg::BIT_RETRY_FF)
      | (48'(mstate.p3_inconsistent) << ipb_pkg::BIT_CONSIST)
      | (48'(rom_err) << ipb_pkg::BIT_HW_ROM) // RQ3 RQ25
      | (48'(ram_err) << ipb_pkg::BIT_HW_RAM) // RQ4 RQ25
      | (48'(bus_err) << ipb_pkg::BIT_HW_BUS) // RQ5 RQ25
      | (48'(adder_err) << ipb_pkg::BIT_HW_ADDER) // RQ6 RQ25
      | (48'(compare_err) << ipb_pkg::BIT_HW_COMPARE); // RQ7 RQ25
   assign gc_p1 = (48'h1 << ipb_pkg::BIT_GENERAL) // RQ10
      | (48'(mstate.value_call) << ipb_pkg::BIT_VALUE_CALL) // RQ11
      | (48'(mstate.vector_op) << ipb_pkg::BIT_VECTOR_OP) // RQ11
      | (48'(mstate.retry_ff) << ipb_pkg::BIT_RETRY_FF) // RQ12
      | (48'(mstate.global_scan) << ipb_pkg::BIT_SCAN) // RQ12
      | (48'(mem_single_corrected) << ipb_pkg::BIT_GC_SINGLE) // RQ10
      | (48'(mem_data_retry) << ipb_pkg::BIT_GC_DATA_RETRY) // RQ10
      | (48'(check_only) << ipb_pkg::BIT_GC_CHECK) // RQ13
      | (48'(retry_pass) << ipb_pkg::BIT_GC_ADDR_RETRY); // RQ15
   assign al_p1 = (48'h1 << ipb_pkg::BIT_ALARM)
      | (48'(mstate.retry_ff) << ipb_pkg::BIT_RETRY_FF)
      | (48'(mstate.p3_inconsistent) << ipb_pkg::BIT_CONSIST)
      | (48'(multi_bit) << ipb_pkg::BIT_AL_MULTI) // RQ14
      | (48'(retry_fail) << ipb_pkg::BIT_AL_ADDR); // RQ15
   assign sd_p1 = (48'(sd_consistent) << ipb_pkg::BIT_SD_HI) // RQ23
      | (48'(!sd_consistent) << ipb_pkg::BIT_SD_LO) // RQ23
      | (48'(sd_presence[2]) << ipb_pkg::BIT_PB_A) // RQ20
      | (48'(sd_presence[1]) << ipb_pkg::BIT_PB_B) // RQ20
      | (48'(sd_presence[0]) << ipb_pkg::BIT_PB_C) // RQ20
      | (48'(mstate.vector_op) << ipb_pkg::BIT_VECTOR_OP)
      | (48'(mstate.retry_ff) << ipb_pkg::BIT_RETRY_FF)
      | 48'(sd_cause);

   // Selection in fixed priority: alarm, hardware, general control, syllable, external
   wire ipb_pkg::ipb_class_t sel_class;
   wire ipb_pkg::ipb_params_t sel_params;

   assign sel_class = alarm_any ? ipb_pkg::IPB_CLS_ALARM
      : hw_any ? ipb_pkg::IPB_CLS_HW
      : gc_any ? ipb_pkg::IPB_CLS_GC
      : sd_event ? ipb_pkg::IPB_CLS_SD
      : io_take ? ipb_pkg::IPB_CLS_EXT
      : ipb_pkg::IPB_CLS_NONE;
   assign sel_params.p1 = alarm_any ? al_p1 : hw_any ? hw_p1 : gc_any ? gc_p1
      : sd_event ? sd_p1 : ipb_pkg::EXT_P1; // RQ16
   assign sel_params.p2 = (alarm_any | hw_any | gc_any) ? mstate.top_of_stack // RQ9
      : sd_event ? sd_p2 : ipb_pkg::WORD_ZERO; // RQ17
   assign sel_params.p3 = (hw_any & ~alarm_any) ? build_p3(mstate, parity_card) // RQ2
      : (alarm_any | gc_any | sd_event) ? build_p3(mstate, 8'h00) // RQ1
      : ipb_pkg::WORD_ZERO; // RQ17

   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         retry_state <= IPB_RT_IDLE;
         io_pending <= 1'b0;
         int_valid <= 1'b0;
         int_class <= ipb_pkg::IPB_CLS_NONE;
         params <= '0;
         stack_second <= ipb_pkg::WORD_ZERO;
         stack_first_clear <= 1'b0;
         iw_pointer_backup <= 1'b0;
         all_pointer_backup <= 1'b0;
         residue_capture <= 4'h0;
         mem_retry_request <= 1'b0;
         error_log_request <= 1'b0;
      end
      else
      begin
         retry_state <= next_retry_state;
         // A completion arriving while an older one is taken stays pending
         io_pending <= (io_event & (io_pending | ~io_take)) | (io_pending & ~io_take); // RQ18
         int_valid <= sel_class != ipb_pkg::IPB_CLS_NONE;
         int_class <= sel_class;
         // Words are latched together with the event, never later
         if (sel_class != ipb_pkg::IPB_CLS_NONE)
         begin
            params <= sel_params; // RQ24
            stack_second <= sel_params.p1; // RQ21
         end
         stack_first_clear <= sel_class != ipb_pkg::IPB_CLS_NONE; // RQ8 RQ21
         iw_pointer_backup <= sel_class != ipb_pkg::IPB_CLS_NONE; // RQ8 RQ21
         all_pointer_backup <= (sel_class == ipb_pkg::IPB_CLS_SD) & sd_consistent; // RQ19
         if (bus_err)
            residue_capture <= bad_residue; // RQ5
         else if (adder_err)
            residue_capture <= bad_residue; // RQ6
         else if (compare_err)
            residue_capture <= comparator; // RQ7
         mem_retry_request <= retry_start; // RQ15
         error_log_request <= check_only; // RQ13
      end
   end

   // Checks on the design's own outputs
   sequence s_check_only;
      mem_read_done && mem_check_bit_err && !mem_data_bit_err && !hw_any && !retry_fail;
   endsequence

   property p_hw_p1;
      @(posedge core_clk) disable iff (reset)
      int_valid && int_class == ipb_pkg::IPB_CLS_HW |-> params.p1[26] && !params.p1[22];
   endproperty
   a_hw_p1: assert property (p_hw_p1) else $error("hardware word lacks class bit"); // RQ22

   property p_ext_words;
      @(posedge core_clk) disable iff (reset)
      int_valid && int_class == ipb_pkg::IPB_CLS_EXT
         |-> params.p1 == 48'h0000_0010_0091 && params.p2 == 48'h0 && params.p3 == 48'h0;
   endproperty
   a_ext_words: assert property (p_ext_words) else $error("bad I/O finished words"); // RQ16

   property p_tos_copy;
      @(posedge core_clk) disable iff (reset)
      hw_any && !alarm_any |=> int_class == ipb_pkg::IPB_CLS_HW
         && params.p2 == $past(mstate.top_of_stack);
   endproperty
   a_tos_copy: assert property (p_tos_copy) else $error("second word not stack top"); // RQ9

   property p_check_log;
      @(posedge core_clk) disable iff (reset)
      s_check_only |=> error_log_request && params.p1[4] && params.p1[22];
   endproperty
   a_check_log: assert property (p_check_log) else $error("check-bit event lost"); // RQ13

   property p_multi;
      @(posedge core_clk) disable iff (reset)
      mem_read_done && mem_check_bit_err && mem_data_bit_err
         |=> int_class == ipb_pkg::IPB_CLS_ALARM && params.p1[7] && !params.p1[22];
   endproperty
   a_multi: assert property (p_multi) else $error("multi-bit not escalated"); // RQ14

   sequence s_retry_fails;
      retry_state == IPB_RT_IDLE && mem_addr_err ##1 mem_retry_request
         ##[0:40] mem_retry_done && !mem_retry_ok;
   endsequence

   property p_retry_fail;
      @(posedge core_clk) disable iff (reset)
      s_retry_fails |=> int_class == ipb_pkg::IPB_CLS_ALARM && params.p1[1];
   endproperty
   a_retry_fail: assert property (p_retry_fail) else $error("failed retry not alarm"); // RQ15

   property p_entry;
      @(posedge core_clk) disable iff (reset)
      int_valid |-> stack_first_clear && iw_pointer_backup && stack_second == params.p1;
   endproperty
   a_entry: assert property (p_entry) else $error("stack entry incomplete"); // RQ21

   property p_low_field;
      @(posedge core_clk) disable iff (reset)
      hw_any && !alarm_any |=> params.p3[10:0] == ($past(mstate.mode_select)
         ? $past(mstate.micromodule_addr) : $past(mstate.micro_step));
   endproperty
   a_low_field: assert property (p_low_field) else $error("low field wrong source"); // RQ1

   property p_residue_card;
      @(posedge core_clk) disable iff (reset)
      (bus_err || compare_err) && !rom_err && !ram_err && !alarm_any
         |=> params.p3[31:24] == 8'h00;
   endproperty
   a_residue_card: assert property (p_residue_card) else $error("card in residue word"); // RQ2

   property p_sd_class;
      @(posedge core_clk) disable iff (reset)
      sd_event && !alarm_any && !hw_any && !gc_any
         |=> params.p1[24:23] == ($past(sd_consistent) ? 2'b10 : 2'b01)
            && all_pointer_backup == $past(sd_consistent);
   endproperty
   a_sd_class: assert property (p_sd_class) else $error("syllable class wrong"); // RQ23
endmodule

// File: rtl/ipb_pkg.sv
// Package with word layouts, bit positions and types of the interrupt parameter builder
package ipb_pkg;
   localparam int WORD_W = 48;
   localparam int ADDR_W = 20;
   localparam int RES_W = 2;
   localparam int CARD_W = 8;
   localparam int LOW_W = 11;
   // Bit positions in the first words; retry, consistency and vector-op bits are shared by several of them
   localparam int BIT_RETRY_FF = 19;
   localparam int BIT_CONSIST = 17;
   localparam int BIT_SCAN = 18;
   localparam int BIT_VALUE_CALL = 46;
   localparam int BIT_VECTOR_OP = 44;
   localparam int BIT_ALARM = 25;
   localparam int BIT_HARDWARE = 26;
   localparam int BIT_GENERAL = 22;
   localparam int BIT_SD_HI = 24;
   localparam int BIT_SD_LO = 23;
   localparam int BIT_PB_A = 46;
   localparam int BIT_PB_B = 45;
   localparam int BIT_PB_C = 39;
   // Hardware cause flags
   localparam int BIT_HW_ROM = 0;
   localparam int BIT_HW_RAM = 1;
   localparam int BIT_HW_BUS = 2;
   localparam int BIT_HW_ADDER = 3;
   localparam int BIT_HW_COMPARE = 4;
   // General-control cause flags
   localparam int BIT_GC_SINGLE = 0;
   localparam int BIT_GC_DATA_RETRY = 3;
   localparam int BIT_GC_CHECK = 4;
   localparam int BIT_GC_ADDR_RETRY = 5;
   // Alarm cause flags used on escalation
   localparam int BIT_AL_MULTI = 7;
   localparam int BIT_AL_ADDR = 1;
   localparam int SD_CAUSE_W = 14;
   // Third-word field positions
   localparam int P3_CARD_LO = 24;
   localparam int P3_VE = 23;
   localparam int P3_TE = 22;
   localparam int P3_E = 21;
   localparam int P3_V = 20;
   localparam int P3_OP_LO = 16;
   localparam int P3_STROBE_LO = 12;
   localparam int P3_MODE = 11;
   // Fixed first word of the I/O-finished interrupt: bits 20, 7, 4, 0
   localparam logic [47:0] EXT_P1 = 48'h0000_0010_0091;
   localparam logic [47:0] WORD_ZERO = 48'h0000_0000_0000;
   localparam logic [RES_W-1:0] RES_INVALID = 2'h3;
   localparam int CW_FINISH_A = 3;
   localparam int CW_FINISH_B = 2;

   typedef enum logic [2:0]
   {
      IPB_CLS_NONE = 3'b000,
      IPB_CLS_ALARM = 3'b001,
      IPB_CLS_HW = 3'b010,
      IPB_CLS_GC = 3'b011,
      IPB_CLS_SD = 3'b100,
      IPB_CLS_EXT = 3'b101
   } ipb_class_t;

   // Machine state sampled at detection time
   typedef struct packed {
      logic [47:0] top_of_stack;
      logic [10:0] micro_step;
      logic [10:0] micromodule_addr;
      logic mode_select;
      logic [3:0] opcode;
      logic [3:0] strobe;
      logic vector_mode_flag;
      logic table_edit_flag;
      logic edit_flag;
      logic variant_flag;
      logic retry_ff;
      logic p3_inconsistent;
      logic value_call;
      logic vector_op;
      logic global_scan;
   } ipb_mstate_t;

   typedef struct packed {
      logic [47:0] p1;
      logic [47:0] p2;
      logic [47:0] p3;
   } ipb_params_t;
endpackage

// File: rtl/ipb_parity_check.sv
// Odd-parity checker for a microcode store or scratch RAM read port
`timescale 1ns/10ps
module ipb_parity_check #(parameter int DATA_W = 32)
(
   // Read port under test
   input wire logic access,
   input wire logic [DATA_W-1:0] data,
   input wire logic parity,
   // Result
   output logic error
);
   wire logic odd_ok;

   // Stored parity makes the total count of ones odd
   assign odd_ok = ^{data, parity};
   assign error = access & ~odd_ok;
endmodule

// File: rtl/ipb_residue_check.sv
// Mod-3 residue checks around the address adder
`timescale 1ns/10ps
module ipb_residue_check
(
   // Adder operands and their carried residues
   input wire logic active,
   input wire logic [ipb_pkg::ADDR_W-1:0] bus_a,
   input wire logic [ipb_pkg::ADDR_W-1:0] bus_b,
   input wire logic [ipb_pkg::RES_W-1:0] res_a,
   input wire logic [ipb_pkg::RES_W-1:0] res_b,
   input wire logic [ipb_pkg::ADDR_W:0] adder_sum,
   // Errors and captured values
   output logic bus_err,
   output logic adder_err,
   output logic compare_err,
   output logic [3:0] bad_residue,
   output logic [3:0] comparator
);
   function automatic logic [1:0] mod3(input logic [ipb_pkg::ADDR_W:0] v);
      logic [1:0] r;
      r = 2'h0;
      for (int i = ipb_pkg::ADDR_W; i >= 0; i--)
      begin
         r = (r == 2'h0) ? {1'b0, v[i]} : ((r == 2'h1) ? (v[i] ? 2'h0 : 2'h2)
            : (v[i] ? 2'h2 : 2'h1));
      end
      return r;
   endfunction

   wire logic [1:0] calc_a;
   wire logic [1:0] calc_b;
   wire logic [2:0] res_sum;
   wire logic [1:0] res_sum_mod;
   wire logic [1:0] result_res;
   wire logic bad_a;
   wire logic bad_b;

   assign calc_a = mod3({1'b0, bus_a});
   assign calc_b = mod3({1'b0, bus_b});
   assign bad_a = res_a == ipb_pkg::RES_INVALID;
   assign bad_b = res_b == ipb_pkg::RES_INVALID;
   assign res_sum = {1'b0, res_a} + {1'b0, res_b};
   assign res_sum_mod = (res_sum >= 3'h3) ? 2'(res_sum - 3'h3) : res_sum[1:0];
   assign result_res = mod3(adder_sum);
   assign bus_err = active & (bad_a | bad_b);
   assign adder_err = active & ~bad_a & ~bad_b & ((res_a != calc_a) | (res_b != calc_b));
   assign compare_err = active & ~bad_a & ~bad_b & (res_sum_mod != result_res);
   assign bad_residue = {res_b, res_a};
   assign comparator = {res_sum_mod, result_res};
endmodule

// File: dv/ipb_mem_model.sv
// Memory controller model answering address retry requests after a delay
`timescale 1ns/10ps
module ipb_mem_model #(parameter int LAT = 3)
(
   // Clock, reset and retry handshake
   input wire logic core_clk,
   input wire logic reset,
   input wire logic retry_req,
   input wire logic retry_pass,
   output logic retry_done,
   output logic retry_ok
);
   int cnt;
   always_ff @(posedge core_clk)
   begin
      retry_done <= !reset && cnt == 1;
      // Outcome line is not held between answers
      retry_ok <= reset ? 1'b0 : ((cnt == 1) ? retry_pass : ~retry_ok);
      cnt <= reset ? 0 : (retry_req ? LAT : (cnt > 0 ? cnt - 1 : 0));
   end
endmodule

// File: dv/tb_ipb_builder.sv
// Self-checking testbench of the interrupt parameter builder
`timescale 1ns/10ps
module tb_ipb_builder;
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   ipb_pkg::ipb_mstate_t ms = '{top_of_stack: 48'h1234_5678_9ABC, micro_step: 11'h5A5,
      micromodule_addr: 11'h7FF, opcode: 4'hA, strobe: 4'h5, default: '0};
   logic rom_acc = 1'b0, rom_par = 1'b0, ram_acc = 1'b0, ram_par = 1'b0, add_act = 1'b0;
   logic rd_done = 1'b0, ck_err = 1'b0, dt_err = 1'b0, addr_err = 1'b0, pass = 1'b0;
   logic io_done = 1'b0, sd_ev = 1'b0, sd_cons = 1'b0, single = 1'b0, dretry = 1'b0;
   logic [2:0] pres = 3'h0;
   logic [47:0] ram_data = 48'h0, cw = 48'h0;
   logic [19:0] bus_a = 20'h0, bus_b = 20'h0;
   logic [1:0] res_a = 2'h0, res_b = 2'h0;
   logic [20:0] sum = 21'h0;
   logic int_valid, sfc, iwb, apb, rreq, elog, rdone, rok;
   ipb_pkg::ipb_class_t int_class;
   ipb_pkg::ipb_params_t params;
   logic [47:0] stack_second;
   logic [3:0] res_cap;
   int miscompares = 0, cmp_count = 0;
   ipb_builder dut (.core_clk(core_clk), .reset(reset), .mstate(ms),
      .rom_access(rom_acc), .rom_data(32'h0), .rom_parity(rom_par), .rom_card(8'hC3),
      .ram_access(ram_acc), .ram_data(ram_data), .ram_parity(ram_par), .ram_card(8'h3C),
      .adder_active(add_act), .adder_input_bus_a(bus_a), .adder_input_bus_b(bus_b),
      .residue_a(res_a), .residue_b(res_b), .adder_sum(sum), .mem_read_done(rd_done),
      .mem_check_bit_err(ck_err), .mem_data_bit_err(dt_err), .mem_single_corrected(single),
      .mem_data_retry(dretry), .mem_addr_err(addr_err), .mem_retry_done(rdone),
      .mem_retry_ok(rok), .io_op_done(io_done), .io_control_word(cw), .sd_event(sd_ev),
      .sd_consistent(sd_cons), .sd_presence(pres), .sd_cause(14'h0), .sd_p2(48'h0),
      .int_valid(int_valid), .int_class(int_class), .params(params),
      .stack_second(stack_second), .stack_first_clear(sfc), .iw_pointer_backup(iwb),
      .all_pointer_backup(apb), .residue_capture(res_cap), .mem_retry_request(rreq),
      .error_log_request(elog));
   ipb_mem_model u_mem (.core_clk(core_clk), .reset(reset), .retry_req(rreq),
      .retry_pass(pass), .retry_done(rdone), .retry_ok(rok));
   always #2 core_clk = ~core_clk;
   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Drops every event pulse after the edge that takes it
   task automatic go;
      @(posedge core_clk);
      {rom_acc, ram_acc, add_act, rd_done, addr_err, io_done, sd_ev, single, dretry} <= 9'h000;
      #1;
   endtask
   task automatic hw(input logic [47:0] p1, input logic [47:0] p3);
      chk(int_valid, 48'h1);
      chk(int_class, 48'h2);
      chk(params.p1, p1);
      chk(params.p2, ms.top_of_stack);
      chk(params.p3, p3);
      chk(stack_second, p1);
      chk({sfc, iwb}, 48'h3);
   endtask
   task automatic t_parity;
      @(posedge core_clk);
      rom_acc <= 1'b1;
      go;
      hw(48'h400_0001, 48'hC30A_55A5);
      @(posedge core_clk);
      ms.mode_select <= 1'b1;
      {ram_acc, ram_par, ram_data, add_act, res_a} <= {2'h3, 48'h1, 1'b1, 2'h3};
      #1;
      chk(int_valid, 48'h0);
      go;
      hw(48'h400_0006, 48'h3C0A_5FFF);
      chk(res_cap, 48'h3);
      $display("parity test done");
   endtask
   task automatic t_res;
      @(posedge core_clk);
      ms.mode_select <= 1'b0;
      add_act <= 1'b1;
      {bus_a, res_a, bus_b, res_b, sum} <= {20'h5, 2'h1, 20'h0, 2'h0, 21'h1};
      go;
      hw(48'h400_0008, 48'h0A_55A5);
      chk(res_cap, 48'h1);
      @(posedge core_clk);
      add_act <= 1'b1;
      {bus_a, res_a, bus_b, res_b, sum} <= {20'h4, 2'h1, 20'h2, 2'h2, 21'h7};
      go;
      hw(48'h400_0010, 48'h0A_55A5);
      chk(res_cap, 48'h1);
      $display("residue test done");
   endtask
   task automatic t_mem;
      @(posedge core_clk);
      {ms.value_call, ms.vector_op, ms.retry_ff, rd_done, ck_err} <= 5'h1F;
      go;
      chk(int_class, 48'h3);
      chk(params.p1, 48'h5000_0048_0010);
      chk(elog, 48'h1);
      @(posedge core_clk);
      {ms.value_call, ms.vector_op, ms.retry_ff, rd_done, dt_err} <= 5'h3;
      go;
      chk(int_class, 48'h1);
      chk(params.p1[7], 48'h1);
      chk(elog, 48'h0);
      @(posedge core_clk);
      {ms.global_scan, dt_err, single, dretry} <= 4'hB;
      go;
      chk(int_class, 48'h3);
      chk(params.p1, 48'h44_0009);
      $display("check-bit test done");
   endtask
   task automatic t_retry(input logic ok, input logic [47:0] cls, input logic [47:0] p1);
      int n;
      @(posedge core_clk);
      {ms.global_scan, pass, addr_err} <= {1'b0, ok, 1'b1};
      go;
      chk(rreq, 48'h1);
      n = 0;
      while (int_valid !== 1'b1 && n < 20)
      begin
         @(posedge core_clk);
         #1;
         n++;
      end
      chk(int_class, cls);
      chk(params.p1, p1);
      $display("retry test done");
   endtask
   task automatic t_io(input logic [47:0] w, input logic fire);
      @(posedge core_clk);
      {cw, io_done} <= {w, 1'b1};
      go;
      chk(int_valid, fire);
      if (fire)
      begin
         chk(int_class, 48'h5);
         chk(params.p1, 48'h0000_0010_0091);
         chk(params.p2 | params.p3, 48'h0);
      end
      $display("io test done");
   endtask
   task automatic t_sd(input logic c);
      @(posedge core_clk);
      {sd_cons, sd_ev, pres} <= {c, 1'b1, c, ~c, 1'b1};
      go;
      chk(int_class, 48'h4);
      chk(params.p1[24:23], {c, ~c});
      chk(apb, c);
      chk({params.p1[46:45], params.p1[39]}, {c, ~c, 1'b1});
      $display("syllable test done");
   endtask
   task automatic results;
      $display("%0d compares, %0d miscompares", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial
   begin
      repeat (8) @(posedge core_clk);
      reset <= 1'b0;
      t_parity;
      t_res;
      t_mem;
      t_retry(1'b1, 48'h3, 48'h40_0020);
      t_retry(1'b0, 48'h1, 48'h200_0002);
      t_io(48'h8, 1'b1);
      t_io(48'h4, 1'b1);
      t_io(48'h3, 1'b0);
      t_sd(1'b1);
      t_sd(1'b0);
      results;
   end
   // Run needs about 46 cycles
   initial
   begin
      #4000;
      miscompares++;
      results;
   end
endmodule
